// *** include/lbd_defs.svh ***
// register offsets, field positions, reset values and timing counts
// assumes a byte-wide register port and a 20 MHz core clock
`ifndef LBD_DEFS_SVH
`define LBD_DEFS_SVH

`define LBD_ADDR_ENA 8'h10
`define LBD_ADDR_CTRL 8'h11
`define LBD_ADDR_MSB 8'h19
`define LBD_ADDR_LSB 8'h1a
`define LBD_ADDR_IMAX 8'h1b
`define LBD_ADDR_STAT_CODE 8'h20
`define LBD_ADDR_STAT_FLAG 8'h21

`define LBD_MODE_HI 6
`define LBD_MODE_LO 5
`define LBD_RAMP_BIT 4
`define LBD_ENA_HI 3
`define LBD_ENA_LO 1

`define LBD_MODE_RST 2'h3
`define LBD_CODE_RST 12'hfff
`define LBD_LSB_RST 4'hf
`define LBD_ENA_RST 3'h7
`define LBD_IMAX_RST 2'h0
`define LBD_CTRL_LOW_RD 4'h5

`define LBD_CLK_MHZ 20
`define LBD_RAMP_FAST_US 128
`define LBD_RAMP_SLOW_US 1024
`define LBD_RAMP_FAST_CYC (`LBD_RAMP_FAST_US * `LBD_CLK_MHZ)
`define LBD_RAMP_SLOW_CYC (`LBD_RAMP_SLOW_US * `LBD_CLK_MHZ)
`define LBD_DUTY_WIN_LOG2 15

`define LBD_CHOP_LOW_DUTY 9'h010
`define LBD_CHOP_PWM_DUTY 9'h020
`define LBD_CHOP_FULL 9'h100
`define LBD_CHOP_MID_AMP 16'h0800
`define LBD_CHOP_PWM_LIMIT 16'h0100
`define LBD_IMAX_BASE 3'h5

`endif

// *** include/lbd_pkg.sv ***
// types shared by the dimming control block
// assumes nothing beyond the constants header
package lbd_pkg;
	typedef enum logic [1:0] {
		LBD_SRC_HOST = 2'b00,
		LBD_SRC_PWM = 2'b01,
		LBD_SRC_PROD = 2'b10,
		LBD_SRC_PROD_ALT = 2'b11
	} lbd_src_type;

	typedef enum logic [0:0] {
		LBD_RAMP_IDLE = 1'b0,
		LBD_RAMP_MOVE = 1'b1
	} lbd_ramp_type;
endpackage

// *** src/lbd_duty_meter.sv ***
// measures pwm input duty over a fixed window of core clocks
// assumes pwm_in is already synchronous; window must be at most 2^15 clocks
`include "lbd_defs.svh"
module lbd_duty_meter #(
	parameter int WIN_LOG2 = `LBD_DUTY_WIN_LOG2
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic pwm_in,
	output logic [15:0] duty_out
);
	logic [WIN_LOG2-1:0] cnt_ff;
	logic [WIN_LOG2-1:0] nxt_cnt;
	logic [WIN_LOG2:0] high_ff;
	logic [WIN_LOG2:0] nxt_high;
	logic [WIN_LOG2:0] high_sum;
	logic [15:0] sum16;
	logic [15:0] nxt_duty;

	// a window spans many input periods, so the count is a block mean, restarted every window
	assign high_sum = high_ff + {{WIN_LOG2{1'b0}}, pwm_in};
	assign sum16 = 16'(high_sum);

	always_comb begin
		nxt_cnt = cnt_ff + 1'b1;
		nxt_high = high_sum;
		nxt_duty = duty_out;
		if (&cnt_ff) begin
			nxt_high = '0;
			// full duty maps to 32768 whatever the window length
			nxt_duty = sum16 << (15 - WIN_LOG2);
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			cnt_ff <= '0;
			high_ff <= '0;
			duty_out <= 16'h0000;
		end else begin
			cnt_ff <= nxt_cnt;
			high_ff <= nxt_high;
			duty_out <= nxt_duty;
		end
	end
endmodule

// *** src/lbd_phase_chopper.sv ***
// chops the sink enables at a given duty with staggered phases
// assumes duty_in counts in 1/2^CNT_W steps, 2^CNT_W meaning always on
module lbd_phase_chopper #(
	parameter int CNT_W = 8,
	parameter int SINKS = 3
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [CNT_W:0] duty_in,
	input wire logic [SINKS-1:0] sink_en_in,
	output logic [SINKS-1:0] sink_on_out
);
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic [SINKS-1:0] nxt_on;

	assign nxt_cnt = cnt_ff + 1'b1;

	// each sink opens its window a fixed fraction of a period later
	for (genvar i = 0; i < SINKS; i++) begin : g_sink
		localparam logic [CNT_W-1:0] OFS = CNT_W'((i * (1 << CNT_W)) / SINKS);
		logic [CNT_W-1:0] phase;
		assign phase = cnt_ff + OFS;
		assign nxt_on[i] = sink_en_in[i] && ({1'b0, phase} < duty_in);
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			cnt_ff <= '0;
			sink_on_out <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
			sink_on_out <= nxt_on;
		end
	end
endmodule

// *** src/lbd_dimming_ctrl.sv ***
// brightness control for a three-string led sink: mode select, code mapping,
// ramping, chopping and scaling to the maximum-current setting
// assumes a byte register port with read data one cycle after the strobe,
// and current outputs in units of one eightieth of the minimum step
//
// How it works
// - two-bit field picks host, pwm or product
// - host mode ignores pwm; code is msb:lsb
// - low nibble waits until upper byte written
// - codes 256-4095 give half-code average current
// - codes 16-255 chop at fixed peak
// - codes 1-15 exponential, 16/256 duty chopping
// - code zero is off; current scales with maximum
// - host ramp: 128us or 1024us per step
// - pwm mode ignores code, never ramps
// - pwm duty maps to code, full gives 2048
// - pwm code below 16 chops at 1/8
// - product code is half host code times duty
// - product codes are fractional, up to 2047
// - product code below 16 chops at 1/8
// - product ramp rate from host nibble only
// - chopped sinks are staggered, not simultaneous
// - maximum field selects 25, 30, 35, 40mA
// - reset: ramp off, source selection 11
// - reset: brightness code all ones
`include "lbd_defs.svh"
module lbd_dimming_ctrl #(
	parameter int RAMP_SLOW_CYC = `LBD_RAMP_SLOW_CYC,
	parameter int DUTY_WIN_LOG2 = `LBD_DUTY_WIN_LOG2
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic pwm_in,
	output logic [2:0] sink_on_out,
	output logic [18:0] sink_amplitude_out,
	output logic [18:0] average_sink_current_out
);
	// register group
	lbd_pkg::lbd_src_type mode_ff;
	lbd_pkg::lbd_src_type nxt_mode;
	logic ramp_en_ff;
	logic nxt_ramp_en;
	logic [2:0] sink_en_ff;
	logic [2:0] nxt_sink_en;
	logic [1:0] imax_ff;
	logic [1:0] nxt_imax;
	logic [3:0] lsb_pend_ff;
	logic [3:0] nxt_lsb_pend;
	logic [11:0] target_ff;
	logic [11:0] nxt_target;
	logic [7:0] nxt_rdata;
	// ramp group
	lbd_pkg::lbd_ramp_type ramp_state_ff;
	lbd_pkg::lbd_ramp_type nxt_ramp_state;
	logic [11:0] code_ff;
	logic [11:0] nxt_code;
	logic [15:0] tick_cnt_ff;
	logic [15:0] nxt_tick_cnt;
	logic [15:0] tick_limit;
	logic tick;
	// output group
	logic [15:0] avg_q_ff;
	logic [15:0] nxt_avg_q;
	logic [15:0] amp_q_ff;
	logic [15:0] nxt_amp_q;
	logic [8:0] duty_ff;
	logic [8:0] nxt_duty;
	logic [18:0] nxt_avg_out;
	logic [18:0] nxt_amp_out;
	logic [15:0] duty_norm;
	logic [26:0] prod;
	logic [15:0] ext_q;
	logic [3:0] scale;

	// current in sixteenths of the minimum step, 1.149 per code from code 1
	function automatic logic [15:0] lbd_exp_q4(input logic [3:0] c);
		case (c)
			4'h1: lbd_exp_q4 = 16'h0010;
			4'h2: lbd_exp_q4 = 16'h0012;
			4'h3: lbd_exp_q4 = 16'h0015;
			4'h4: lbd_exp_q4 = 16'h0018;
			4'h5: lbd_exp_q4 = 16'h001c;
			4'h6: lbd_exp_q4 = 16'h0020;
			4'h7: lbd_exp_q4 = 16'h0025;
			4'h8: lbd_exp_q4 = 16'h002a;
			4'h9: lbd_exp_q4 = 16'h0031;
			4'ha: lbd_exp_q4 = 16'h0038;
			4'hb: lbd_exp_q4 = 16'h0040;
			4'hc: lbd_exp_q4 = 16'h004a;
			4'hd: lbd_exp_q4 = 16'h0055;
			4'he: lbd_exp_q4 = 16'h0061;
			4'hf: lbd_exp_q4 = 16'h0070;
			default: lbd_exp_q4 = 16'h0000;
		endcase
	endfunction

	// pwm-only is the one source that bypasses both the code and the ramp
	function automatic logic lbd_uses_code(input lbd_pkg::lbd_src_type m);
		lbd_uses_code = (m != lbd_pkg::LBD_SRC_PWM);
	endfunction

	lbd_duty_meter #(
		.WIN_LOG2(DUTY_WIN_LOG2)
	) u_meter (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.pwm_in(pwm_in),
		.duty_out(duty_norm)
	);

	lbd_phase_chopper #(
		.CNT_W(8),
		.SINKS(3)
	) u_chop (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.duty_in(duty_ff),
		.sink_en_in(sink_en_ff),
		.sink_on_out(sink_on_out)
	);

	// register file
	always_comb begin
		nxt_mode = mode_ff;
		nxt_ramp_en = ramp_en_ff;
		nxt_sink_en = sink_en_ff;
		nxt_imax = imax_ff;
		nxt_lsb_pend = lsb_pend_ff;
		nxt_target = target_ff;
		nxt_rdata = 8'h00;
		if (reg_wr_in) begin
			case (reg_addr_in)
				`LBD_ADDR_ENA: nxt_sink_en = reg_wdata_in[`LBD_ENA_HI:`LBD_ENA_LO];
				`LBD_ADDR_CTRL: begin
					nxt_mode = lbd_pkg::lbd_src_type'(reg_wdata_in[`LBD_MODE_HI:`LBD_MODE_LO]);
					nxt_ramp_en = reg_wdata_in[`LBD_RAMP_BIT];
				end
				`LBD_ADDR_LSB: nxt_lsb_pend = reg_wdata_in[3:0];
				`LBD_ADDR_MSB: nxt_target = {reg_wdata_in, lsb_pend_ff};
				`LBD_ADDR_IMAX: nxt_imax = reg_wdata_in[1:0];
				default: nxt_target = target_ff;
			endcase
		end
		if (reg_rd_in) begin
			case (reg_addr_in)
				`LBD_ADDR_ENA: nxt_rdata = {4'h0, sink_en_ff, 1'b0};
				`LBD_ADDR_CTRL: nxt_rdata = {1'b0, mode_ff, ramp_en_ff, `LBD_CTRL_LOW_RD};
				`LBD_ADDR_LSB: nxt_rdata = {4'h0, lsb_pend_ff};
				`LBD_ADDR_MSB: nxt_rdata = target_ff[11:4];
				`LBD_ADDR_IMAX: nxt_rdata = {6'h00, imax_ff};
				`LBD_ADDR_STAT_CODE: nxt_rdata = code_ff[11:4];
				`LBD_ADDR_STAT_FLAG: nxt_rdata = {ramp_state_ff,
					(duty_ff != `LBD_CHOP_FULL) && (duty_ff != 9'h000), 2'h0, code_ff[3:0]};
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			mode_ff <= lbd_pkg::lbd_src_type'(`LBD_MODE_RST);
			ramp_en_ff <= 1'b0;
			sink_en_ff <= `LBD_ENA_RST;
			imax_ff <= `LBD_IMAX_RST;
			lsb_pend_ff <= `LBD_LSB_RST;
			target_ff <= `LBD_CODE_RST;
			reg_rdata_out <= 8'h00;
		end else begin
			mode_ff <= nxt_mode;
			ramp_en_ff <= nxt_ramp_en;
			sink_en_ff <= nxt_sink_en;
			imax_ff <= nxt_imax;
			lsb_pend_ff <= nxt_lsb_pend;
			target_ff <= nxt_target;
			reg_rdata_out <= nxt_rdata;
		end
	end

	// ramp: the effective code moves one half-code unit per tick
	assign tick_limit = (target_ff[11:8] != 4'h0) ? 16'(`LBD_RAMP_FAST_CYC - 1)
		: 16'(RAMP_SLOW_CYC - 1);
	// >= so a shorter interval chosen mid-count still fires
	assign tick = (tick_cnt_ff >= tick_limit);

	always_comb begin
		nxt_ramp_state = ramp_state_ff;
		nxt_code = code_ff;
		nxt_tick_cnt = (tick || ramp_state_ff == lbd_pkg::LBD_RAMP_IDLE) ? 16'h0000
			: tick_cnt_ff + 16'h0001;
		if (!ramp_en_ff || !lbd_uses_code(mode_ff)) begin
			nxt_code = target_ff;
			nxt_ramp_state = lbd_pkg::LBD_RAMP_IDLE;
		end else begin
			case (ramp_state_ff)
				lbd_pkg::LBD_RAMP_IDLE: begin
					if (code_ff != target_ff)
						nxt_ramp_state = lbd_pkg::LBD_RAMP_MOVE;
				end
				lbd_pkg::LBD_RAMP_MOVE: begin
					if (tick) begin
						if (code_ff < target_ff)
							nxt_code = (target_ff - code_ff > 12'h002) ? code_ff + 12'h002
								: target_ff;
						else
							nxt_code = (code_ff - target_ff > 12'h002) ? code_ff - 12'h002
								: target_ff;
						if (nxt_code == target_ff)
							nxt_ramp_state = lbd_pkg::LBD_RAMP_IDLE;
					end
				end
				default: nxt_ramp_state = lbd_pkg::LBD_RAMP_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			ramp_state_ff <= lbd_pkg::LBD_RAMP_IDLE;
			code_ff <= `LBD_CODE_RST;
			tick_cnt_ff <= 16'h0000;
		end else begin
			ramp_state_ff <= nxt_ramp_state;
			code_ff <= nxt_code;
			tick_cnt_ff <= nxt_tick_cnt;
		end
	end

	// code to current mapping in sixteenths of a step; scale reaches 8, so four bits
	assign prod = code_ff[11:1] * duty_norm;
	assign ext_q = (mode_ff == lbd_pkg::LBD_SRC_PWM) ? duty_norm
		: 16'(prod >> 11);
	assign scale = 4'(`LBD_IMAX_BASE) + {2'b00, imax_ff};

	always_comb begin
		nxt_avg_q = 16'h0000;
		nxt_amp_q = 16'h0000;
		nxt_duty = 9'h000;
		case (mode_ff)
			lbd_pkg::LBD_SRC_HOST: begin
				if (code_ff == 12'h000) begin
					nxt_duty = 9'h000;
				end else if (code_ff < 12'h010) begin
					nxt_avg_q = lbd_exp_q4(code_ff[3:0]);
					nxt_amp_q = lbd_exp_q4(code_ff[3:0]) << 4;
					nxt_duty = `LBD_CHOP_LOW_DUTY;
				end else if (code_ff < 12'h100) begin
					nxt_avg_q = {1'b0, code_ff[11:1], 4'h0};
					nxt_amp_q = `LBD_CHOP_MID_AMP;
					nxt_duty = {1'b0, code_ff[7:1], 1'b0};
				end else begin
					nxt_avg_q = {1'b0, code_ff[11:1], 4'h0};
					nxt_amp_q = {1'b0, code_ff[11:1], 4'h0};
					nxt_duty = `LBD_CHOP_FULL;
				end
			end
			default: begin
				if (ext_q == 16'h0000) begin
					nxt_duty = 9'h000;
				end else if (ext_q < `LBD_CHOP_PWM_LIMIT) begin
					nxt_avg_q = ext_q;
					nxt_amp_q = ext_q << 3;
					nxt_duty = `LBD_CHOP_PWM_DUTY;
				end else begin
					nxt_avg_q = ext_q;
					nxt_amp_q = ext_q;
					nxt_duty = `LBD_CHOP_FULL;
				end
			end
		endcase
		nxt_avg_out = 19'(19'(avg_q_ff) * 19'(scale));
		nxt_amp_out = 19'(19'(amp_q_ff) * 19'(scale));
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			avg_q_ff <= 16'h0000;
			amp_q_ff <= 16'h0000;
			duty_ff <= 9'h000;
			average_sink_current_out <= 19'h00000;
			sink_amplitude_out <= 19'h00000;
		end else begin
			avg_q_ff <= nxt_avg_q;
			amp_q_ff <= nxt_amp_q;
			duty_ff <= nxt_duty;
			average_sink_current_out <= nxt_avg_out;
			sink_amplitude_out <= nxt_amp_out;
		end
	end

	AST_MSB_LOAD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		reg_wr_in && reg_addr_in == `LBD_ADDR_MSB
		|=> target_ff == {$past(reg_wdata_in), $past(lsb_pend_ff)})
		else $error("upper byte write did not apply the code");

	AST_LSB_HOLD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		reg_wr_in && reg_addr_in == `LBD_ADDR_LSB |=> $stable(target_ff))
		else $error("low nibble write changed the applied code");

	AST_RST_MODE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		$past(sys_rst_in) |-> mode_ff == lbd_pkg::LBD_SRC_PROD_ALT && !ramp_en_ff)
		else $error("wrong mode or ramp after reset");

	AST_RST_CODE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		$past(sys_rst_in) |-> target_ff == 12'hfff && lsb_pend_ff == 4'hf)
		else $error("brightness code not all ones after reset");

	AST_ZERO_OFF: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		mode_ff == lbd_pkg::LBD_SRC_HOST && code_ff == 12'h000
		|=> ##1 average_sink_current_out == 19'h00000)
		else $error("code zero did not give zero current");

	AST_LOW_CHOP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		mode_ff == lbd_pkg::LBD_SRC_HOST && code_ff != 12'h000 && code_ff < 12'h010
		|=> duty_ff == 9'h010 && amp_q_ff == (avg_q_ff << 4))
		else $error("low code chopping wrong");

	AST_MID_CHOP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		mode_ff == lbd_pkg::LBD_SRC_HOST && code_ff >= 12'h010 && code_ff < 12'h100
		|=> amp_q_ff == 16'h0800 && duty_ff == {1'b0, $past(code_ff[7:1]), 1'b0})
		else $error("mid code chopping wrong");

	AST_HIGH_LIN: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		mode_ff == lbd_pkg::LBD_SRC_HOST && code_ff >= 12'h100
		|=> duty_ff == 9'h100 && avg_q_ff == {1'b0, $past(code_ff[11:1]), 4'h0})
		else $error("high code not half-code continuous");

	AST_PWM_LOW: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		mode_ff == lbd_pkg::LBD_SRC_PWM && duty_norm != 16'h0000 && duty_norm < 16'h0100
		|=> duty_ff == 9'h020 && amp_q_ff == {avg_q_ff[12:0], 3'h0})
		else $error("low pwm code not chopped at one eighth");

	AST_RAMP_STEP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		ramp_en_ff && lbd_uses_code(mode_ff) && ramp_state_ff == lbd_pkg::LBD_RAMP_MOVE && !tick
		|=> $stable(code_ff))
		else $error("ramp moved between ticks");
endmodule

// *** tb/lbd_host_pwm.sv ***
// host-side pwm source with a fixed 256-clock period and programmable high time
// assumes the 20 MHz core clock; high_in of 256 holds the line high
module lbd_host_pwm (
	input wire logic clk_in,
	input wire logic [8:0] high_in,
	output logic pwm_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_ff = 8'h00;
	// 256 clocks at 20 MHz is about 78 kHz, inside the allowed band
	always_ff @(posedge clk_in) cnt_ff <= cnt_ff + 8'h01;
	assign pwm_out = {1'b0, cnt_ff} < high_in;
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the dimming control block
// assumes the pwm partner model; long counts shortened through parameters
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [7:0] reg_addr_in = 8'h00;
	logic [7:0] reg_wdata_in = 8'h00;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [7:0] reg_rdata_out;
	logic pwm;
	logic [8:0] high = 9'h080;
	logic [2:0] sink_on_out;
	logic [18:0] amp;
	logic [18:0] avg;
	int n_fail = 0;
	int samples_checked = 0;
	int cyc = 0;
	int seed = 32'hea3b;
	int n0;
	int nall;
	logic [11:0] c;
	logic [7:0] d;

	always #25 clk_in = ~clk_in;

	lbd_host_pwm u_lbd_host_pwm (.clk_in(clk_in), .high_in(high), .pwm_out(pwm));

	lbd_dimming_ctrl #(.RAMP_SLOW_CYC(64), .DUTY_WIN_LOG2(8)) u_lbd_dimming_ctrl (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out),
		.pwm_in(pwm),
		.sink_on_out(sink_on_out),
		.sink_amplitude_out(amp),
		.average_sink_current_out(avg)
	);

	function automatic logic [31:0] host_avg(input logic [11:0] k, input logic [1:0] im);
		if (k == 12'h001) begin
			return 32'h10 * (32'h5 + im);
		end
		return {20'h0, k >> 1} * 32'h10 * (32'h5 + im);
	endfunction

	// half duty from the partner makes the product an exact integer
	function automatic logic [31:0] prod_avg(input logic [11:0] k);
		return {20'h0, k >> 1} * 32'h28;
	endfunction

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// ends off the edge so that registered outputs have settled
	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
		@(negedge clk_in);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= v;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		@(negedge clk_in);
		v = reg_rdata_out;
	endtask

	// low nibble first, the upper byte applies the code
	task automatic setc(input logic [11:0] k);
		wr(8'h1a, {4'h0, k[3:0]});
		wr(8'h19, k[11:4]);
		wt(8);
	endtask

	// one full chop period
	task automatic meas;
		n0 = 0;
		nall = 0;
		repeat (256) begin
			@(negedge clk_in);
			n0 += (sink_on_out[0] === 1'b1);
			nall += (sink_on_out === 3'h7);
		end
	endtask

	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (12) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		rd(8'h11, d);
		chk(d, 8'h65);
		rd(8'h19, d);
		chk(d, 8'hff);
		rd(8'h1b, d);
		chk(d, 8'h00);
		rd(8'h05, d);
		chk(d, 8'h00);
		wr(8'h11, 8'h00);
		high <= 9'h001;
		for (int i = 0; i < 4; i++) begin
			wr(8'h1b, 8'(i));
			setc(12'hfff);
			chk(avg, host_avg(12'hfff, 2'(i)));
		end
		wr(8'h1b, 8'h00);
		setc(12'h080);
		chk(avg, host_avg(12'h080, 2'h0));
		chk(amp, 32'h2800);
		meas();
		chk(n0, 128);
		chk(nall, 0);
		wr(8'h10, 8'h04);
		wt(4);
		meas();
		chk(n0, 0);
		wr(8'h10, 8'h0e);
		setc(12'h001);
		chk(avg, 32'h50);
		chk(amp, 32'h500);
		meas();
		chk(n0, 16);
		setc(12'h000);
		chk(avg, 32'h0);
		chk(sink_on_out, 3'h0);
		setc(12'h800);
		wr(8'h1a, 8'h0f);
		wt(8);
		chk(avg, host_avg(12'h800, 2'h0));
		wr(8'h19, 8'h80);
		wt(8);
		chk(avg, host_avg(12'h80f, 2'h0));
		setc(12'h000);
		wr(8'h11, 8'h10);
		wr(8'h1a, 8'h00);
		wr(8'h19, 8'h01);
		wt(100);
		chk(avg !== host_avg(12'h010, 2'h0), 1);
		wt(600);
		chk(avg, host_avg(12'h010, 2'h0));
		wr(8'h11, 8'h00);
		setc(12'h100);
		wr(8'h11, 8'h10);
		wr(8'h1a, 8'h04);
		wr(8'h19, 8'h10);
		wt(1000);
		chk(avg !== host_avg(12'h104, 2'h0), 1);
		rd(8'h21, d);
		chk(d, 8'h80);
		wt(4400);
		chk(avg, host_avg(12'h104, 2'h0));
		rd(8'h20, d);
		chk(d, 8'h10);
		rd(8'h21, d);
		chk(d, 8'h04);
		// pwm-only with ramp still enabled: no stepping expected
		wr(8'h11, 8'h30);
		high <= 9'h080;
		wt(600);
		chk(avg, 32'h14000);
		setc(12'h800);
		chk(avg, 32'h14000);
		high <= 9'h001;
		wt(600);
		chk(avg, 32'h280);
		chk(amp, 32'h1400);
		meas();
		chk(n0, 32);
		high <= 9'h100;
		wt(600);
		chk(avg, 32'h28000);
		wr(8'h11, 8'h40);
		high <= 9'h080;
		wt(600);
		setc(12'hfff);
		chk(avg, prod_avg(12'hfff));
		setc(12'h01e);
		chk(avg, prod_avg(12'h01e));
		chk(amp, 32'h12c0);
		repeat (6) begin
			c = 12'($random(seed));
			setc(c);
			chk(avg, prod_avg(c));
		end
		wr(8'h11, 8'h60);
		wt(8);
		chk(avg, prod_avg(c));
		tally_and_finish();
	end
endmodule
